// ===== dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "xps_cfg.svh"
module testbench;
    localparam int W = `XPS_NUM_SW;
    localparam logic [2:0] DEV_SEL = 3'h5;
    typedef struct packed {
        logic rd;
        logic [2:0] sel;
        logic [15:0] word;
        logic [W-1:0] sw;
        logic nack;
        logic [7:0] rdata;
    } xps_row_t;
    logic clk_i;
    logic rst_i;
    logic reset_n_i;
    logic cmd_valid;
    logic cmd_read;
    logic [2:0] cmd_sel;
    logic [15:0] cmd_word;
    logic cmd_ready;
    logic done;
    logic nack;
    logic [7:0] rd_data;
    logic [W-1:0] switch_closed;
    logic [7:0] first_byte;
    logic [2:0] dev_sel;
    int bit_n = 8;
    int n_errors = 0;
    int check_count = 0;
    xps_row_t rows [9];

    xps_link_if u_xps_link_if ();
    xps_switch_host u_xps_switch_host (
        .CLK_I(clk_i),
        .RST_I(rst_i),
        .link(u_xps_link_if),
        .CMD_VALID_I(cmd_valid),
        .CMD_READ_I(cmd_read),
        .CMD_ADDR_SEL_I(cmd_sel),
        .CMD_WORD_I(cmd_word),
        .CMD_READY_O(cmd_ready),
        .DONE_O(done),
        .NACK_O(nack),
        .RD_DATA_O(rd_data)
    );
    xps_switch_dev u_xps_switch_dev (
        .link(u_xps_link_if),
        .RST_I(rst_i),
        .RESET_N_I(reset_n_i),
        .ADDR_SELECT_BITS_I(dev_sel),
        .SWITCH_CLOSED_O(switch_closed)
    );
    xps_link_sva u_xps_link_sva (
        .CLK_I(clk_i),
        .RST_I(rst_i),
        .RESET_N_I(reset_n_i),
        .ADDR_SELECT_BITS_I(dev_sel),
        .scl(u_xps_link_if.scl),
        .sda(u_xps_link_if.sda),
        .sda_dev_oe_n(u_xps_link_if.sda_dev_oe_n)
    );

    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request is held until the edge that sees ready, then waits for done
    task automatic run_cmd(input logic rd, input logic [2:0] sel, input logic [15:0] word);
        int n;
        n = 0;
        @(negedge clk_i);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_sel = sel;
        cmd_word = word;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 100) n_errors++;
        @(negedge clk_i);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 8000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 8000) n_errors++;
    endtask : run_cmd

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // about 76k cycles of traffic expected
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    // first byte after each start, as seen on the wire
    always @(negedge u_xps_link_if.sda) begin
        if (u_xps_link_if.scl === 1'b1) bit_n = 0;
    end
    always @(posedge u_xps_link_if.scl) begin
        if (bit_n < 8) begin
            first_byte = {first_byte[6:0], u_xps_link_if.sda};
            bit_n++;
        end
    end

    initial begin
        rst_i = 1'b1;
        reset_n_i = 1'b1;
        dev_sel = DEV_SEL;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_sel = DEV_SEL;
        cmd_word = 16'h0;
        first_byte = 8'h0;
        rows[0] = '{1'b0, DEV_SEL, 16'h90FF, 80'h1, 1'b0, 8'h0};
        rows[1] = '{1'b0, DEV_SEL, 16'hEF01, 80'h8000_0000_0000_0000_0001, 1'b0, 8'h0};
        rows[2] = '{1'b0, DEV_SEL, 16'hB301, 80'h8000_0000_0000_0000_0001, 1'b0, 8'h0};
        rows[3] = '{1'b0, 3'h2, 16'h9801, 80'h8000_0000_0000_0000_0001, 1'b1, 8'h0};
        rows[4] = '{1'b1, DEV_SEL, 16'h0, 80'h8000_0000_0000_0000_0001, 1'b0, 8'h80};
        rows[5] = '{1'b0, DEV_SEL, 16'hAA00, 80'h8000_0000_0000_0000_0001, 1'b0, 8'h0};
        rows[6] = '{1'b0, DEV_SEL, 16'hAD01, 80'h8000_0000_0000_2400_0001, 1'b0, 8'h0};
        rows[7] = '{1'b1, DEV_SEL, 16'h0, 80'h8000_0000_0000_2400_0001, 1'b0, 8'h24};
        rows[8] = '{1'b0, DEV_SEL, 16'h6F01, 80'h0000_0000_0000_2400_0001, 1'b0, 8'h0};
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        check("switch_closed", switch_closed, '0);
        foreach (rows[i]) begin
            run_cmd(rows[i].rd, rows[i].sel, rows[i].word);
            check("switch_closed", switch_closed, rows[i].sw);
            check("nack", W'(nack), W'(rows[i].nack));
            check("addr_byte", W'(first_byte), W'({`XPS_ADDR_HI, rows[i].sel, rows[i].rd}));
            if (rows[i].rd) check("rd_data", W'(rd_data), W'(rows[i].rdata));
        end
        // reset pin while idle, then the array must answer from scratch
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("switch_closed", switch_closed, '0);
        reset_n_i = 1'b1;
        run_cmd(1'b1, DEV_SEL, 16'h0);
        check("rd_data", W'(rd_data), '0);
        run_cmd(1'b0, DEV_SEL, 16'h9B01);
        check("switch_closed", switch_closed, 80'h800);
        // other strap setting, first code of the upper row range
        dev_sel = 3'h2;
        run_cmd(1'b0, 3'h2, 16'hC401);
        check("nack", W'(nack), '0);
        check("switch_closed", switch_closed, 80'h10_0000_0800);
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// ===== dv/xps_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "xps_cfg.svh"
module xps_link_sva (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic RESET_N_I,
    input wire logic [2:0] ADDR_SELECT_BITS_I,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe_n
);
    logic scl_q;
    logic sda_q;
    logic [4:0] idx;
    logic [7:0] addr_sr;
    logic rise;
    logic match;

    // scl is slow against CLK_I, so sampling it here sees every edge
    assign rise = scl & ~scl_q;
    assign match = (addr_sr[7:1] == {`XPS_ADDR_HI, ADDR_SELECT_BITS_I});

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I || !RESET_N_I);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // pulse index since the last start, taken at each scl rise
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            idx <= 5'h0;
        end else if (scl && scl_q && sda_q && !sda) begin
            idx <= 5'h0;
        end else if (rise) begin
            idx <= idx + 5'h1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_sr <= 8'h0;
        end else if (rise && idx < 5'h8) begin
            addr_sr <= {addr_sr[6:0], sda};
        end
    end

    property p_dev_edge;
        $changed(sda_dev_oe_n) |-> !scl;
    endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("device moved sda while scl high");

    property p_start;
        $fell(sda) && scl && scl_q |-> ##[1:200] $fell(scl);
    endproperty
    a_start: assert property (p_start) else $error("no clock pulse after start");

    property p_stop;
        $rose(sda) && scl && scl_q |-> scl [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("clock moved after stop");

    property p_addr_quiet;
        rise && idx < 5'h8 |-> sda_dev_oe_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("device drove address bits");

    property p_ack_addr;
        rise && idx == 5'h8 && match |-> !sda;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

    property p_idle_other;
        rise && idx >= 5'h8 && !match |-> sda_dev_oe_n;
    endproperty
    a_idle_other: assert property (p_idle_other) else $error("unaddressed device drove sda");

    property p_wr_quiet;
        rise && idx > 5'h8 && !addr_sr[0] && idx != 5'h11 && idx != 5'h1A |-> sda_dev_oe_n;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("device drove write data bit");

    property p_ack_data;
        rise && match && !addr_sr[0] && (idx == 5'h11 || idx == 5'h1A) |-> !sda;
    endproperty
    a_ack_data: assert property (p_ack_data) else $error("command byte not acknowledged");

    property p_read_nack;
        rise && match && addr_sr[0] && idx == 5'h11 |-> sda && sda_dev_oe_n;
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("read ack slot not high");

    property p_reset_rel;
        disable iff (RST_I) !RESET_N_I |-> sda_dev_oe_n;
    endproperty
    a_reset_rel: assert property (p_reset_rel) else $error("device drove sda in reset");
endmodule : xps_link_sva
`default_nettype wire

// ===== verilog/xps_cfg.svh
`ifndef XPS_CFG_SVH
`define XPS_CFG_SVH

// slave address and switch array shape
`define XPS_ADDR_HI 4'hE
`define XPS_NUM_ROWS 10
`define XPS_NUM_COLS 8
`define XPS_NUM_SW 80
`define XPS_SW_RESET 80'h0

// command word field positions
`define XPS_DATA_BIT 15
`define XPS_ROW_MSB 14
`define XPS_ROW_LSB 11
`define XPS_COL_MSB 10
`define XPS_COL_LSB 8
`define XPS_LOAD_BIT 0

// row code ranges
`define XPS_ROW_LO_FIRST 4'h2
`define XPS_ROW_LO_LAST 4'h5
`define XPS_ROW_HI_FIRST 4'h8
`define XPS_ROW_HI_LAST 4'hD
`define XPS_ROW_HI_BASE 4'h4

// pulse counter values inside one nine-pulse byte
`define XPS_LAST_BIT 4'h7
`define XPS_ACK_SLOT 4'h8

// host serial clock timing
`define XPS_CLK_NS 10
`define XPS_SCL_PERIOD_NS 2500
`define XPS_QTR_CYC ((`XPS_SCL_PERIOD_NS + 4 * `XPS_CLK_NS - 1) / (4 * `XPS_CLK_NS))

`endif

// ===== verilog/xps_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface xps_link_if;
    logic scl_host_o;
    logic scl_host_oe_n;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic scl;
    logic sda;
    // open-drain wires with pull-ups: a released pin reads high
    assign scl = scl_host_oe_n | scl_host_o;
    assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
    modport dev(input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
    modport host(input sda, output scl_host_o, output scl_host_oe_n,
                 output sda_host_o, output sda_host_oe_n);
endinterface : xps_link_if
`default_nettype wire

// ===== verilog/xps_pkg.sv
package xps_pkg;
    typedef enum logic [1:0] {DS_IDLE, DS_ADDR, DS_WR, DS_RD} xps_dev_state_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} xps_host_state_t;
endpackage : xps_pkg

// ===== verilog/xps_switch_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "xps_cfg.svh"
// Overview of operation
// - reset pin low opens all switches, clears state
// - power-on reset leaves everything zero until written
// - load flag set applies word after shift-in
// - load-clear words are held, applied together later
// - master can read back the applied switch states of the last written row
// - slave only, never drives the clock
// - address is 1110 plus three select pins
// - works at any clock rate up to 3.4 MHz
// - start then eight bits: address MSB first, direction
// - matching slave acks ninth pulse, others stay idle
// - direction 1 reads, 0 writes
// - nine pulses per byte, receiver acknowledges
// - data changes while clock low only
// - rising data with clock high ends transfer
// - master reads with nack then stop
// - any row/column combination may be closed
// - three-byte write: address byte, then a 16-bit command word
// - close bit, row, column and load fields
// - row code decode, reserved codes, binary columns
// - reset pin stays high during writes
module xps_switch_dev (
    xps_link_if.dev link,
    input wire logic RST_I,
    input wire logic RESET_N_I,
    input wire logic [2:0] ADDR_SELECT_BITS_I,
    output logic [`XPS_NUM_SW-1:0] SWITCH_CLOSED_O
);

    function automatic logic [4:0] xps_row_decode(input logic [3:0] code);
        logic [4:0] res;
        res = 5'h00;
        if (code >= `XPS_ROW_LO_FIRST && code <= `XPS_ROW_LO_LAST) begin
            res = {1'b1, code - `XPS_ROW_LO_FIRST};
        end else if (code >= `XPS_ROW_HI_FIRST && code <= `XPS_ROW_HI_LAST) begin
            res = {1'b1, code - `XPS_ROW_HI_BASE};
        end
        return res;
    endfunction : xps_row_decode

    logic arst;
    logic start_tgl;
    logic stop_tgl;
    logic start_seen;
    logic stop_seen;
    logic start_evt;
    logic stop_evt;
    logic [2:0] addr_meta;
    logic [2:0] addr_sync;
    logic [7:0] shreg;
    logic sda_r;
    xps_pkg::xps_dev_state_t state;
    logic [3:0] cnt;
    logic bytec;
    logic rw;
    logic [7:0] word_hi;
    logic [7:0] word_lo;
    logic [7:0] txsh;
    logic sda_oe_n;
    logic [`XPS_NUM_SW-1:0] pending;
    logic [`XPS_NUM_SW-1:0] next_pending;
    logic [3:0] row_last;
    logic [4:0] row_dec;
    logic [15:0] word;
    logic [7:0] rd_byte;
    logic commit;

    // pin reset and power-on reset both act at once, without the clock
    assign arst = RST_I | ~RESET_N_I;

    // the bus clock stands still between frames, so start and stop are
    // caught on the data edges and handed over as toggles; the clock
    // always falls well after a start, which makes the toggle settle
    always_ff @(negedge link.sda or posedge arst) begin
        if (arst) begin
            start_tgl <= 1'b0;
        end else if (link.scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge link.sda or posedge arst) begin
        if (arst) begin
            stop_tgl <= 1'b0;
        end else if (link.scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    assign start_evt = start_tgl != start_seen;
    assign stop_evt = stop_tgl != stop_seen;

    // select pins are static straps, synchronised to the bus clock
    always_ff @(posedge link.scl or posedge arst) begin
        if (arst) begin
            addr_meta <= 3'h0;
            addr_sync <= 3'h0;
        end else begin
            addr_meta <= ADDR_SELECT_BITS_I;
            addr_sync <= addr_meta;
        end
    end

    // data is sampled while the clock is high; nothing here depends on
    // the bit rate, so standard, fast and high speed all work
    always_ff @(posedge link.scl or posedge arst) begin
        if (arst) begin
            shreg <= 8'h00;
            sda_r <= 1'b1;
        end else begin
            shreg <= {shreg[6:0], link.sda};
            sda_r <= link.sda;
        end
    end

    assign word = {word_hi, word_lo};
    assign rd_byte = SWITCH_CLOSED_O[{row_last, 3'h0} +: 8];
    assign row_dec = xps_row_decode(word[`XPS_ROW_MSB:`XPS_ROW_LSB]);

    // the word is complete once its last acknowledge pulse has ended
    assign commit = state == xps_pkg::DS_WR && cnt == `XPS_ACK_SLOT && bytec
                    && !start_evt && !stop_evt;

    // transfer sequencing; outputs change only on the falling clock edge
    always_ff @(negedge link.scl or posedge arst) begin
        if (arst) begin
            state <= xps_pkg::DS_IDLE;
            cnt <= 4'h0;
            bytec <= 1'b0;
            rw <= 1'b0;
            word_hi <= 8'h00;
            word_lo <= 8'h00;
            txsh <= 8'h00;
            sda_oe_n <= 1'b1;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            start_seen <= start_tgl;
            stop_seen <= stop_tgl;
            if (start_evt) begin
                state <= xps_pkg::DS_ADDR;
                cnt <= 4'h0;
                bytec <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (stop_evt) begin
                state <= xps_pkg::DS_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                unique case (state)
                    xps_pkg::DS_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    xps_pkg::DS_ADDR: begin
                        if (cnt == `XPS_LAST_BIT) begin
                            cnt <= `XPS_ACK_SLOT;
                            if (shreg[7:1] == {`XPS_ADDR_HI, addr_sync}) begin
                                sda_oe_n <= 1'b0;
                                rw <= shreg[0];
                            end else begin
                                state <= xps_pkg::DS_IDLE;
                            end
                        end else if (cnt == `XPS_ACK_SLOT) begin
                            cnt <= 4'h0;
                            if (rw) begin
                                state <= xps_pkg::DS_RD;
                                sda_oe_n <= rd_byte[7];
                                txsh <= {rd_byte[6:0], 1'b0};
                            end else begin
                                state <= xps_pkg::DS_WR;
                                sda_oe_n <= 1'b1;
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    xps_pkg::DS_WR: begin
                        if (cnt == `XPS_LAST_BIT) begin
                            cnt <= `XPS_ACK_SLOT;
                            sda_oe_n <= 1'b0;
                            if (bytec) begin
                                word_lo <= shreg;
                            end else begin
                                word_hi <= shreg;
                            end
                        end else if (cnt == `XPS_ACK_SLOT) begin
                            cnt <= 4'h0;
                            sda_oe_n <= 1'b1;
                            bytec <= ~bytec;
                            // extra bytes after the word are not acknowledged
                            if (bytec) begin
                                state <= xps_pkg::DS_IDLE;
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    xps_pkg::DS_RD: begin
                        if (cnt == `XPS_LAST_BIT) begin
                            cnt <= `XPS_ACK_SLOT;
                            sda_oe_n <= 1'b1;
                        end else if (cnt == `XPS_ACK_SLOT) begin
                            cnt <= 4'h0;
                            if (sda_r) begin
                                state <= xps_pkg::DS_IDLE;
                            end else begin
                                sda_oe_n <= rd_byte[7];
                                txsh <= {rd_byte[6:0], 1'b0};
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                            sda_oe_n <= txsh[7];
                            txsh <= {txsh[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        next_pending = pending;
        if (row_dec[4]) begin
            next_pending[{row_dec[3:0], word[`XPS_COL_MSB:`XPS_COL_LSB]}] =
                word[`XPS_DATA_BIT];
        end
    end

    // held positions and the applied array; each bit is independent
    always_ff @(negedge link.scl or posedge arst) begin
        if (arst) begin
            pending <= `XPS_SW_RESET;
            SWITCH_CLOSED_O <= `XPS_SW_RESET;
            row_last <= 4'h0;
        end else if (commit && row_dec[4]) begin
            pending <= next_pending;
            row_last <= row_dec[3:0];
            if (word[`XPS_LOAD_BIT]) begin
                SWITCH_CLOSED_O <= next_pending;
            end
        end
    end

    // open-drain data only; the clock line has no driver here
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe_n = sda_oe_n;

endmodule : xps_switch_dev
`default_nettype wire

// ===== verilog/xps_switch_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "xps_cfg.svh"
module xps_switch_host (
    input wire logic CLK_I,
    input wire logic RST_I,
    xps_link_if.host link,
    input wire logic CMD_VALID_I,
    input wire logic CMD_READ_I,
    input wire logic [2:0] CMD_ADDR_SEL_I,
    input wire logic [15:0] CMD_WORD_I,
    output logic CMD_READY_O,
    output logic DONE_O,
    output logic NACK_O,
    output logic [7:0] RD_DATA_O
);

    xps_pkg::xps_host_state_t state;
    logic [7:0] qcnt;
    logic tick;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] bytei;
    logic [7:0] sh;
    logic rd;
    logic [15:0] word;
    logic scl_oe_n;
    logic sda_oe_n;
    logic sda_meta;
    logic sda_s;
    logic rx_byte;

    assign tick = qcnt == 8'(`XPS_QTR_CYC - 1);
    assign rx_byte = rd && bytei == 2'h1;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_meta <= link.sda;
            sda_s <= sda_meta;
        end
    end

    // quarter-period divider for the bus clock
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            qcnt <= 8'h00;
        end else if (state == xps_pkg::HS_IDLE || tick) begin
            qcnt <= 8'h00;
        end else begin
            qcnt <= qcnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= xps_pkg::HS_IDLE;
            ph <= 2'h0;
            bitn <= 4'h0;
            bytei <= 2'h0;
            sh <= 8'h00;
            rd <= 1'b0;
            word <= 16'h0000;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            CMD_READY_O <= 1'b0;
            DONE_O <= 1'b0;
            NACK_O <= 1'b0;
            RD_DATA_O <= 8'h00;
        end else begin
            DONE_O <= 1'b0;
            if (state == xps_pkg::HS_IDLE) begin
                CMD_READY_O <= 1'b1;
                if (CMD_VALID_I && CMD_READY_O) begin
                    CMD_READY_O <= 1'b0;
                    NACK_O <= 1'b0;
                    rd <= CMD_READ_I;
                    word <= CMD_WORD_I;
                    sh <= {`XPS_ADDR_HI, CMD_ADDR_SEL_I, CMD_READ_I};
                    ph <= 2'h0;
                    state <= xps_pkg::HS_START;
                end
            end else if (tick) begin
                ph <= ph + 2'h1;
                unique case (state)
                    xps_pkg::HS_START: begin
                        if (ph == 2'h0) begin
                            sda_oe_n <= 1'b0;
                        end else if (ph == 2'h2) begin
                            scl_oe_n <= 1'b0;
                        end else if (ph == 2'h3) begin
                            bitn <= 4'h0;
                            bytei <= 2'h0;
                            state <= xps_pkg::HS_BIT;
                        end
                    end
                    xps_pkg::HS_BIT: begin
                        if (ph == 2'h0) begin
                            // ack slot and read data are left to the device;
                            // leaving the read ack high is the nack
                            sda_oe_n <= (bitn == `XPS_ACK_SLOT || rx_byte) | sh[7];
                        end else if (ph == 2'h1) begin
                            scl_oe_n <= 1'b1;
                        end else if (ph == 2'h2) begin
                            if (bitn != `XPS_ACK_SLOT) begin
                                sh <= {sh[6:0], sda_s};
                            end else if (!rx_byte && sda_s) begin
                                NACK_O <= 1'b1;
                            end
                        end else begin
                            scl_oe_n <= 1'b0;
                            if (bitn != `XPS_ACK_SLOT) begin
                                bitn <= bitn + 4'h1;
                            end else begin
                                bitn <= 4'h0;
                                bytei <= bytei + 2'h1;
                                sh <= bytei == 2'h0 ? word[15:8] : word[7:0];
                                if (rx_byte) begin
                                    RD_DATA_O <= sh;
                                end
                                if (NACK_O || rx_byte || bytei == 2'h2) begin
                                    state <= xps_pkg::HS_STOP;
                                end
                            end
                        end
                    end
                    xps_pkg::HS_STOP: begin
                        if (ph == 2'h0) begin
                            sda_oe_n <= 1'b0;
                        end else if (ph == 2'h1) begin
                            scl_oe_n <= 1'b1;
                        end else if (ph == 2'h2) begin
                            sda_oe_n <= 1'b1;
                        end else begin
                            DONE_O <= 1'b1;
                            CMD_READY_O <= 1'b1;
                            state <= xps_pkg::HS_IDLE;
                        end
                    end
                    xps_pkg::HS_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe_n = scl_oe_n;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe_n = sda_oe_n;

endmodule : xps_switch_host
`default_nettype wire
